/* rtl/param_store.sv */
// Purpose: Nonvolatile parameter store, one word per slot
// Assumes: Single clock; write and read never target one slot in one cycle
// Notes: Read data comes from a register, one cycle after the read enable
`timescale 1ns/1ps
module param_store #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule // param_store

/* rtl/pmb_pkg.sv */
// Purpose: Shared constants, types and helpers for the power module command block
// Assumes: Command codes, encodings and defaults of the converter management interface
// Notes: Linear encodings only; every exponent is fixed per command
package pmb_pkg;

  // Transfer kinds as delivered by the bus front end
  typedef enum logic [2:0] {
    KIND_SEND = 3'h0,
    KIND_WRITE_BYTE = 3'h1,
    KIND_WRITE_WORD = 3'h2,
    KIND_READ_BYTE = 3'h3,
    KIND_READ_WORD = 3'h4
  } xfer_kind_e;

  // Sequencer states, Gray along idle-store and idle-restore
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_STORE = 2'h1,
    ST_RESTORE = 2'h2
  } ctl_state_e;

  typedef struct packed {
    xfer_kind_e kind;
    logic [7:0] code;
    logic [15:0] data;
    logic [7:0] pec;
    logic pec_en;
  } req_s;

  typedef struct packed {
    logic [15:0] data;
    logic [7:0] pec;
    logic err;
  } resp_s;

  // Command codes
  localparam logic [7:0] CMD_ON_OFF_CONTROL = 8'h01;
  localparam logic [7:0] CMD_ON_OFF_SOURCE_CONFIG = 8'h02;
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_STORE_ALL = 8'h11;
  localparam logic [7:0] CMD_RESTORE_ALL = 8'h12;
  localparam logic [7:0] CMD_OUTPUT_FORMAT_REPORT = 8'h20;
  localparam logic [7:0] CMD_OUTPUT_SETPOINT = 8'h21;
  localparam logic [7:0] CMD_SWITCHING_FREQUENCY = 8'h33;
  localparam logic [7:0] CMD_OV_FAULT_LIMIT = 8'h40;

  // Reset values and the fixed format descriptor
  localparam logic [7:0] ON_OFF_CONTROL_RST = 8'h80;
  localparam logic [7:0] ON_OFF_CONFIG_NEG = 8'h1D;
  localparam logic [7:0] ON_OFF_CONFIG_POS = 8'h1F;
  localparam logic [7:0] OUTPUT_FORMAT_REPORT_VAL = 8'h14;
  localparam logic [15:0] SETPOINT_RST = 16'hC000;
  localparam logic [15:0] FREQ_RST = 16'hF208;
  localparam logic [15:0] OV_LIMIT_RST = 16'hF000;

  // Output-voltage encoding: unsigned 16-bit mantissa, implied exponent -12
  localparam logic [15:0] SETPOINT_MIN = 16'h999A;
  localparam logic [15:0] SETPOINT_MAX = 16'hD333;
  localparam logic [15:0] OV_LIMIT_MIN = 16'hB000;

  // Eleven/five encoding: exponent in bits 15:11, mantissa in bits 10:0
  localparam int LIN11_EXP_POS = 11;
  localparam logic [4:0] EXP_VIN = 5'h1D;
  localparam logic [4:0] EXP_IOUT = 5'h1C;
  localparam logic [4:0] EXP_TEMP = 5'h1E;
  localparam logic [4:0] EXP_FREQ = 5'h1E;
  localparam logic [4:0] EXP_TIME = 5'h1F;
  localparam logic [10:0] FREQ_MANT_MIN = 11'h1E0;
  localparam logic [10:0] FREQ_MANT_MAX = 11'h230;

  // Operation and on/off configuration bit positions
  localparam int OP_ON_BIT = 7;
  localparam int CFG_PU_BIT = 4;
  localparam int CFG_CMD_BIT = 3;
  localparam int CFG_PIN_BIT = 2;
  localparam int CFG_POL_BIT = 1;

  // Fault status bit positions; bits 7:4 are external fault events
  localparam int FLT_BAD_CMD = 0;
  localparam int FLT_PEC = 1;
  localparam int FLT_RANGE = 2;
  localparam int FLT_REFUSED = 3;
  localparam int FLT_EXT_POS = 4;

  // Nonvolatile slots
  localparam logic [2:0] SLOT_OP = 3'h0;
  localparam logic [2:0] SLOT_CFG = 3'h1;
  localparam logic [2:0] SLOT_SETPOINT = 3'h2;
  localparam logic [2:0] SLOT_FREQ = 3'h3;
  localparam logic [2:0] SLOT_OV = 3'h4;
  localparam logic [2:0] SLOT_LAST = 3'h4;

  localparam logic [7:0] CRC_POLY = 8'h07;

  // One byte through the packet check CRC-8, polynomial x^8+x^2+x+1
  function automatic logic [7:0] crc8(input logic [7:0] crc_in, input logic [7:0] b);
    logic [7:0] c;
    c = crc_in ^ b;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction

  function automatic logic [4:0] lin11_exp(input logic [15:0] w);
    return w[15:LIN11_EXP_POS];
  endfunction

  function automatic logic [10:0] lin11_mant(input logic [15:0] w);
    return w[LIN11_EXP_POS-1:0];
  endfunction

endpackage

/* rtl/power_cmd.sv */
// Purpose: Command interpreter and linear data formatting for the converter management port
// Assumes: A bus front end delivers whole decoded transactions; inputs synchronous to clk
// Notes: One request at a time; every accepted request gets one response pulse
//
// What this block does
// RULE_01: Linear encodings only, never direct format.
// RULE_02: Each command's exponent fixed, writes cannot rescale.
// RULE_03: Output voltages: unsigned 16-bit mantissa, exponent -12.
// RULE_04: Other quantities: 11-bit mantissa, 5-bit exponent.
// RULE_05: Exponents: Vin -3, Iout -4, temp/freq -2, time -1.
// RULE_06: Code 0x01 on/off byte, resets to 0x80.
// RULE_07: Code 0x02 pin/command combine, 0x1D or 0x1F.
// RULE_08: Code 0x03 clears every set fault bit.
// RULE_09: Code 0x11 copies working parameters to flash.
// RULE_10: Code 0x12 reloads flash; refused while output runs.
// RULE_11: Code 0x20 reads fixed format descriptor 0x14.
// RULE_12: Code 0x21 setpoint, default 12 V, 9.6-13.2 V.
// RULE_13: Code 0x33 frequency, 130 kHz, 120-140 kHz, output off.
// RULE_14: Code 0x40 OV limit 15 V, above setpoint.
// RULE_15: Check incoming PEC, append PEC to responses.
// RULE_16: Fault clearing also releases the alert line.
// RULE_17: Exponent in upper five bits; low byte first.
// RULE_18: Out-of-range writes ignored and flagged as faults.
`timescale 1ns/1ps
module power_cmd #(
  parameter int EXT_FAULTS = 4
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [6:0] dev_addr,
  input wire logic pol_strap,
  input wire logic on_off_pin,
  input wire logic [EXT_FAULTS-1:0] fault_evt,
  input wire logic req_valid,
  input wire pmb_pkg::req_s req,
  output logic req_ready,
  output logic resp_valid,
  output pmb_pkg::resp_s resp,
  output logic conv_on,
  output logic [15:0] vout_setpoint,
  output logic [15:0] freq_setpoint,
  output logic [15:0] ov_limit,
  output logic [7:0] fault_status,
  output logic alert_n
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  pmb_pkg::ctl_state_e state_r, state_nxt;
  logic [2:0] idx_r, idx_nxt;
  logic init_done_r, init_done_nxt;
  logic stored_r, stored_nxt;
  logic rd_vld_r, rd_vld_nxt;
  logic [2:0] rd_slot_r, rd_slot_nxt;
  logic [7:0] op_r, op_nxt;
  logic [7:0] cfg_r, cfg_nxt;
  logic [15:0] setpoint_r, setpoint_nxt;
  logic [15:0] freq_r, freq_nxt;
  logic [15:0] ov_r, ov_nxt;
  logic [7:0] fault_r, fault_nxt;
  logic resp_valid_r, resp_valid_nxt;
  pmb_pkg::resp_s resp_r, resp_nxt;

  logic acc;
  logic is_write;
  logic is_word;
  logic pec_bad;
  logic [7:0] crc_req;
  logic [7:0] crc_rd;
  logic [7:0] set_bits;
  logic clear_now;
  logic [15:0] rd_word;
  logic bad_cmd;
  logic range_bad;
  logic refused;
  logic [7:0] cfg_dflt;
  logic pin_active;
  logic st_wr_en;
  logic [15:0] st_wr_data;
  logic st_rd_en;
  logic [15:0] st_rd_data;

  ////////////////////////////////////////////////////////////////////////////
  // Output enable from pin and command
  assign pin_active = (on_off_pin == cfg_r[pmb_pkg::CFG_POL_BIT]);
  always_comb begin
    if (!cfg_r[pmb_pkg::CFG_PU_BIT]) begin
      conv_on = 1'b1; // RULE_07
    end else begin
      conv_on = (!cfg_r[pmb_pkg::CFG_CMD_BIT] || op_r[pmb_pkg::OP_ON_BIT]) &&
                (!cfg_r[pmb_pkg::CFG_PIN_BIT] || pin_active); // RULE_06 RULE_07
    end
  end

  assign cfg_dflt = pol_strap ? pmb_pkg::ON_OFF_CONFIG_POS : pmb_pkg::ON_OFF_CONFIG_NEG; // RULE_07
  assign req_ready = (state_r == pmb_pkg::ST_IDLE) && init_done_r && !rd_vld_r;
  assign acc = req_valid && req_ready;
  assign is_write = (req.kind == pmb_pkg::KIND_WRITE_BYTE) || (req.kind == pmb_pkg::KIND_WRITE_WORD);
  assign is_word = (req.kind == pmb_pkg::KIND_WRITE_WORD) || (req.kind == pmb_pkg::KIND_READ_WORD);

  ////////////////////////////////////////////////////////////////////////////
  // Packet check: address, code, then data low byte first
  always_comb begin
    crc_req = pmb_pkg::crc8(8'h00, {dev_addr, 1'b0});
    crc_req = pmb_pkg::crc8(crc_req, req.code);
    crc_rd = pmb_pkg::crc8(crc_req, {dev_addr, 1'b1});
    if (is_write) begin
      crc_req = pmb_pkg::crc8(crc_req, req.data[7:0]); // RULE_17
    end
    if (req.kind == pmb_pkg::KIND_WRITE_WORD) begin
      crc_req = pmb_pkg::crc8(crc_req, req.data[15:8]); // RULE_17
    end
    crc_rd = pmb_pkg::crc8(crc_rd, rd_word[7:0]);
    if (req.kind == pmb_pkg::KIND_READ_WORD) begin
      crc_rd = pmb_pkg::crc8(crc_rd, rd_word[15:8]); // RULE_15
    end
  end
  // Reads carry no host check byte, so only sends and writes are verified
  assign pec_bad = req.pec_en && (req.kind <= pmb_pkg::KIND_WRITE_WORD) && (req.pec != crc_req); // RULE_15

  ////////////////////////////////////////////////////////////////////////////
  // Command decode
  always_comb begin
    rd_word = 16'h0000;
    bad_cmd = 1'b0;
    range_bad = 1'b0;
    refused = 1'b0;
    unique case (req.code)
      pmb_pkg::CMD_ON_OFF_CONTROL, pmb_pkg::CMD_ON_OFF_SOURCE_CONFIG: begin
        rd_word = {8'h00, (req.code == pmb_pkg::CMD_ON_OFF_CONTROL) ? op_r : cfg_r};
        bad_cmd = is_word || (req.kind == pmb_pkg::KIND_SEND);
      end
      pmb_pkg::CMD_CLEAR_FAULTS, pmb_pkg::CMD_STORE_ALL, pmb_pkg::CMD_RESTORE_ALL: begin
        bad_cmd = (req.kind != pmb_pkg::KIND_SEND);
        refused = (req.code == pmb_pkg::CMD_RESTORE_ALL) && conv_on; // RULE_10
      end
      pmb_pkg::CMD_OUTPUT_FORMAT_REPORT: begin
        rd_word = {8'h00, pmb_pkg::OUTPUT_FORMAT_REPORT_VAL}; // RULE_11 RULE_01
        bad_cmd = (req.kind != pmb_pkg::KIND_READ_BYTE);
      end
      pmb_pkg::CMD_OUTPUT_SETPOINT: begin
        rd_word = setpoint_r; // RULE_03
        bad_cmd = !is_word;
        range_bad = (req.data < pmb_pkg::SETPOINT_MIN) || (req.data > pmb_pkg::SETPOINT_MAX) ||
                    (req.data >= ov_r); // RULE_12 RULE_14
      end
      pmb_pkg::CMD_SWITCHING_FREQUENCY: begin
        rd_word = freq_r; // RULE_04
        bad_cmd = !is_word;
        // A foreign exponent is rejected rather than rescaled
        range_bad = (pmb_pkg::lin11_exp(req.data) != pmb_pkg::EXP_FREQ) ||
                    (pmb_pkg::lin11_mant(req.data) < pmb_pkg::FREQ_MANT_MIN) ||
                    (pmb_pkg::lin11_mant(req.data) > pmb_pkg::FREQ_MANT_MAX); // RULE_02 RULE_05 RULE_13 RULE_17
        refused = is_write && conv_on; // RULE_13
      end
      pmb_pkg::CMD_OV_FAULT_LIMIT: begin
        rd_word = ov_r;
        bad_cmd = !is_word;
        range_bad = (req.data < pmb_pkg::OV_LIMIT_MIN) || (req.data <= setpoint_r); // RULE_14
      end
      default: begin
        bad_cmd = 1'b1; // RULE_01
      end
    endcase
    if (!is_write) begin
      range_bad = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state of registers, sequencer and faults
  always_comb begin
    state_nxt = state_r;
    idx_nxt = idx_r;
    init_done_nxt = 1'b1;
    stored_nxt = stored_r;
    rd_vld_nxt = 1'b0;
    rd_slot_nxt = idx_r;
    op_nxt = op_r;
    cfg_nxt = init_done_r ? cfg_r : cfg_dflt; // RULE_07
    setpoint_nxt = setpoint_r;
    freq_nxt = freq_r;
    ov_nxt = ov_r;
    set_bits = {fault_evt, 4'h0};
    clear_now = 1'b0;
    resp_valid_nxt = acc;
    resp_nxt = resp_r;
    st_wr_en = 1'b0;
    st_rd_en = 1'b0;
    unique case (idx_r)
      pmb_pkg::SLOT_OP: st_wr_data = {8'h00, op_r};
      pmb_pkg::SLOT_CFG: st_wr_data = {8'h00, cfg_r};
      pmb_pkg::SLOT_SETPOINT: st_wr_data = setpoint_r;
      pmb_pkg::SLOT_FREQ: st_wr_data = freq_r;
      default: st_wr_data = ov_r;
    endcase
    if (acc) begin
      resp_nxt.data = is_write ? 16'h0000 : rd_word;
      resp_nxt.pec = (is_write || req.kind == pmb_pkg::KIND_SEND) ? 8'h00 : crc_rd; // RULE_15
      resp_nxt.err = pec_bad || bad_cmd || range_bad || refused;
      set_bits[pmb_pkg::FLT_PEC] = pec_bad; // RULE_15
      set_bits[pmb_pkg::FLT_BAD_CMD] = !pec_bad && bad_cmd;
      set_bits[pmb_pkg::FLT_RANGE] = !pec_bad && !bad_cmd && range_bad; // RULE_18
      set_bits[pmb_pkg::FLT_REFUSED] = !pec_bad && !bad_cmd && !range_bad && refused; // RULE_10
      if (!resp_nxt.err) begin
        unique case (req.code)
          pmb_pkg::CMD_ON_OFF_CONTROL: if (is_write) op_nxt = req.data[7:0]; // RULE_06
          pmb_pkg::CMD_ON_OFF_SOURCE_CONFIG: if (is_write) cfg_nxt = req.data[7:0]; // RULE_07
          pmb_pkg::CMD_CLEAR_FAULTS: clear_now = 1'b1; // RULE_08
          pmb_pkg::CMD_STORE_ALL: begin
            state_nxt = pmb_pkg::ST_STORE; // RULE_09
            idx_nxt = 3'h0;
          end
          pmb_pkg::CMD_RESTORE_ALL: begin
            if (stored_r) begin
              state_nxt = pmb_pkg::ST_RESTORE; // RULE_10
              idx_nxt = 3'h0;
            end else begin
              // Nothing stored yet: the power-up values are the defaults
              op_nxt = pmb_pkg::ON_OFF_CONTROL_RST;
              cfg_nxt = cfg_dflt;
              setpoint_nxt = pmb_pkg::SETPOINT_RST;
              freq_nxt = pmb_pkg::FREQ_RST;
              ov_nxt = pmb_pkg::OV_LIMIT_RST;
            end
          end
          pmb_pkg::CMD_OUTPUT_SETPOINT: if (is_write) setpoint_nxt = req.data; // RULE_12
          pmb_pkg::CMD_SWITCHING_FREQUENCY: if (is_write) freq_nxt = req.data; // RULE_13
          pmb_pkg::CMD_OV_FAULT_LIMIT: if (is_write) ov_nxt = req.data; // RULE_14
          default: begin
          end
        endcase
      end
    end
    unique case (state_r)
      pmb_pkg::ST_IDLE: begin
      end
      pmb_pkg::ST_STORE: begin
        st_wr_en = 1'b1; // RULE_09
        idx_nxt = 3'(idx_r + 3'h1);
        if (idx_r == pmb_pkg::SLOT_LAST) begin
          state_nxt = pmb_pkg::ST_IDLE;
          stored_nxt = 1'b1;
        end
      end
      pmb_pkg::ST_RESTORE: begin
        st_rd_en = 1'b1;
        rd_vld_nxt = 1'b1;
        idx_nxt = 3'(idx_r + 3'h1);
        if (idx_r == pmb_pkg::SLOT_LAST) begin
          state_nxt = pmb_pkg::ST_IDLE;
        end
      end
      default: state_nxt = pmb_pkg::ST_IDLE;
    endcase
    if (rd_vld_r) begin
      unique case (rd_slot_r)
        pmb_pkg::SLOT_OP: op_nxt = st_rd_data[7:0]; // RULE_10
        pmb_pkg::SLOT_CFG: cfg_nxt = st_rd_data[7:0];
        pmb_pkg::SLOT_SETPOINT: setpoint_nxt = st_rd_data;
        pmb_pkg::SLOT_FREQ: freq_nxt = st_rd_data;
        default: ov_nxt = st_rd_data;
      endcase
    end
    // A fault raised in the clearing cycle survives the clear
    fault_nxt = (clear_now ? 8'h00 : fault_r) | set_bits; // RULE_08
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= pmb_pkg::ST_IDLE;
      idx_r <= 3'h0;
      init_done_r <= 1'b0;
      stored_r <= 1'b0;
      rd_vld_r <= 1'b0;
      rd_slot_r <= 3'h0;
      op_r <= pmb_pkg::ON_OFF_CONTROL_RST; // RULE_06
      cfg_r <= pmb_pkg::ON_OFF_CONFIG_NEG;
      setpoint_r <= pmb_pkg::SETPOINT_RST; // RULE_12
      freq_r <= pmb_pkg::FREQ_RST; // RULE_13
      ov_r <= pmb_pkg::OV_LIMIT_RST; // RULE_14
      fault_r <= 8'h00;
      resp_valid_r <= 1'b0;
      resp_r <= '0;
    end else begin
      state_r <= state_nxt;
      idx_r <= idx_nxt;
      init_done_r <= init_done_nxt;
      stored_r <= stored_nxt;
      rd_vld_r <= rd_vld_nxt;
      rd_slot_r <= rd_slot_nxt;
      op_r <= op_nxt;
      cfg_r <= cfg_nxt;
      setpoint_r <= setpoint_nxt;
      freq_r <= freq_nxt;
      ov_r <= ov_nxt;
      fault_r <= fault_nxt;
      resp_valid_r <= resp_valid_nxt;
      resp_r <= resp_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Nonvolatile store
  param_store #(
    .WIDTH(16),
    .DEPTH(8),
    .AW(3)
  ) u_store (
    .clk(clk),
    .wr_en(st_wr_en),
    .wr_addr(idx_r),
    .wr_data(st_wr_data),
    .rd_en(st_rd_en),
    .rd_addr(idx_r),
    .rd_data(st_rd_data)
  );

  assign resp_valid = resp_valid_r;
  assign resp = resp_r;
  assign vout_setpoint = setpoint_r;
  assign freq_setpoint = freq_r;
  assign ov_limit = ov_r;
  assign fault_status = fault_r;
  assign alert_n = ~|fault_r; // RULE_16

endmodule // power_cmd

/* sim/pmb_host.sv */
// Purpose: Behavioural host controller issuing whole transactions
// Assumes: Drives at the falling edge, holds until taken or 40 cycles pass
// Notes: Released request fields are inverted so stale values cannot pass
`timescale 1ns/1ps
module pmb_host (
  input wire logic clk,
  input wire logic [6:0] dev_addr,
  input wire logic req_ready,
  input wire logic resp_valid,
  input wire pmb_pkg::resp_s resp,
  output logic req_valid,
  output pmb_pkg::req_s req
);
  initial begin
    req_valid = 1'b0;
    req = '0;
  end
  function automatic logic [7:0] crc_byte(input logic [7:0] c, input logic [7:0] b);
    c = c ^ b;
    for (int i = 0; i < 8; i++) c = c[7] ? ((c << 1) ^ 8'h07) : (c << 1);
    return c;
  endfunction
  function automatic logic [7:0] frame_pec(input logic [7:0] cd, input logic rd, input logic [15:0] d, input int n);
    logic [7:0] c;
    c = crc_byte(8'h00, {dev_addr, 1'b0});
    c = crc_byte(c, cd);
    if (rd) c = crc_byte(c, {dev_addr, 1'b1});
    if (n > 0) c = crc_byte(c, d[7:0]);
    if (n > 1) c = crc_byte(c, d[15:8]);
    return c;
  endfunction
  ////////////////////////////////////////
  // Ready is registered state, so its level at the falling edge is what the next rising edge sees
  task automatic xfer(input pmb_pkg::xfer_kind_e k, input logic [7:0] cd, input logic [15:0] d,
    input logic pe, input logic bad, output pmb_pkg::resp_s r, output logic got);
    int n;
    n = (k == pmb_pkg::KIND_WRITE_WORD) ? 2 : (k == pmb_pkg::KIND_WRITE_BYTE) ? 1 : 0;
    got = 1'b0;
    r = '0;
    @(negedge clk);
    req_valid = 1'b1;
    req = '{kind: k, code: cd, data: d, pec: frame_pec(cd, 1'b0, d, n) ^ {7'h00, bad}, pec_en: pe};
    for (int i = 0; i < 40 && !req_ready; i++) @(negedge clk);
    if (req_ready) begin
      @(negedge clk);
      got = resp_valid;
      r = resp;
    end
    req_valid = 1'b0;
    req = ~req;
  endtask
endmodule // pmb_host

/* sim/power_cmd_sva.sv */
// Purpose: Port checks for the command block
// Assumes: One clock, asynchronous active-low reset
// Notes: Attached to every power_cmd by the bind below
`timescale 1ns/1ps
module power_cmd_sva #(
  parameter int EXT_FAULTS = 4
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [6:0] dev_addr,
  input wire logic [EXT_FAULTS-1:0] fault_evt,
  input wire logic req_valid,
  input wire pmb_pkg::req_s req,
  input wire logic req_ready,
  input wire logic resp_valid,
  input wire pmb_pkg::resp_s resp,
  input wire logic conv_on,
  input wire logic [15:0] vout_setpoint,
  input wire logic [15:0] freq_setpoint,
  input wire logic [15:0] ov_limit,
  input wire logic [7:0] fault_status,
  input wire logic alert_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  logic take;
  logic send;
  logic [7:0] pec_hdr;
  logic wr_ok;
  assign take = req_valid && req_ready;
  // A request with a good check byte must act, so checked requests count too
  assign pec_hdr = pmb_pkg::crc8(pmb_pkg::crc8(8'h00, {dev_addr, 1'b0}), req.code);
  assign send = take && req.kind == pmb_pkg::KIND_SEND && (!req.pec_en || req.pec == pec_hdr);
  assign wr_ok = take && req.kind == pmb_pkg::KIND_WRITE_WORD &&
    (!req.pec_en || req.pec == pmb_pkg::crc8(pmb_pkg::crc8(pec_hdr, req.data[7:0]), req.data[15:8]));
  ////////////////////////////////////////
  property p_answer;
    take |=> resp_valid;
  endproperty
  a_answer: assert property (p_answer) else $error("no response after request");
  property p_format;
    take && req.kind == pmb_pkg::KIND_READ_BYTE && req.code == pmb_pkg::CMD_OUTPUT_FORMAT_REPORT
      |=> resp.data == 16'h0014 && !resp.err;
  endproperty
  a_format: assert property (p_format) else $error("format descriptor wrong");
  property p_store;
    send && req.code == pmb_pkg::CMD_STORE_ALL |=> !req_ready [*5] ##1 req_ready;
  endproperty
  a_store: assert property (p_store) else $error("store busy span wrong");
  property p_clear;
    send && req.code == pmb_pkg::CMD_CLEAR_FAULTS && fault_evt == '0 |=> fault_status == 8'h00;
  endproperty
  a_clear: assert property (p_clear) else $error("faults not cleared");
  property p_alert;
    alert_n == (fault_status == 8'h00);
  endproperty
  a_alert: assert property (p_alert) else $error("alert line disagrees with faults");
  property p_range;
    take && req.kind == pmb_pkg::KIND_WRITE_WORD && req.code == pmb_pkg::CMD_OUTPUT_SETPOINT
      && req.data > pmb_pkg::SETPOINT_MAX |=> resp.err && $stable(vout_setpoint);
  endproperty
  a_range: assert property (p_range) else $error("out of range setpoint accepted");
  property p_setpoint;
    wr_ok && req.code == pmb_pkg::CMD_OUTPUT_SETPOINT
      && req.data >= pmb_pkg::SETPOINT_MIN && req.data <= pmb_pkg::SETPOINT_MAX && req.data < ov_limit
      |=> vout_setpoint == $past(req.data);
  endproperty
  a_setpoint: assert property (p_setpoint) else $error("setpoint write lost");
  property p_freq_exp;
    freq_setpoint[15:11] == pmb_pkg::EXP_FREQ;
  endproperty
  a_freq_exp: assert property (p_freq_exp) else $error("frequency exponent changed");
  property p_ov;
    ov_limit > vout_setpoint && ov_limit >= pmb_pkg::OV_LIMIT_MIN;
  endproperty
  a_ov: assert property (p_ov) else $error("overvoltage limit not above setpoint");
  property p_refuse;
    send && req.code == pmb_pkg::CMD_RESTORE_ALL && conv_on |=> resp.err && fault_status[pmb_pkg::FLT_REFUSED];
  endproperty
  a_refuse: assert property (p_refuse) else $error("restore while running not refused");
  c_store: cover property (send && req.code == pmb_pkg::CMD_STORE_ALL);
  c_refuse: cover property (send && req.code == pmb_pkg::CMD_RESTORE_ALL && conv_on);
  c_clear: cover property (send && req.code == pmb_pkg::CMD_CLEAR_FAULTS);
endmodule // power_cmd_sva

bind power_cmd power_cmd_sva #(.EXT_FAULTS(EXT_FAULTS)) u_power_cmd_sva (.clk(clk), .nrst(nrst), .dev_addr(dev_addr),
  .fault_evt(fault_evt), .req_valid(req_valid), .req(req), .req_ready(req_ready), .resp_valid(resp_valid),
  .resp(resp), .conv_on(conv_on), .vout_setpoint(vout_setpoint), .freq_setpoint(freq_setpoint),
  .ov_limit(ov_limit), .fault_status(fault_status), .alert_n(alert_n));

/* sim/power_cmd_test.sv */
// Purpose: Self-checking bench for the command block
// Assumes: Fixed device address; polarity strap set before each reset release
// Notes: Host model makes every transfer; scenarios judge results
`timescale 1ns/1ps
module power_cmd_test;
  logic clk, nrst, pol_strap, on_off_pin, req_valid, req_ready, resp_valid, conv_on, alert_n, got;
  logic [3:0] fault_evt;
  pmb_pkg::req_s req;
  pmb_pkg::resp_s resp, r;
  logic [15:0] vout_setpoint, freq_setpoint, ov_limit;
  logic [7:0] fault_status;
  int miscompares = 0;
  int tests_run = 0;
  power_cmd #(.EXT_FAULTS(4)) u_power_cmd (.clk(clk), .nrst(nrst), .dev_addr(7'h5A), .pol_strap(pol_strap),
    .on_off_pin(on_off_pin), .fault_evt(fault_evt), .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .resp_valid(resp_valid), .resp(resp), .conv_on(conv_on), .vout_setpoint(vout_setpoint),
    .freq_setpoint(freq_setpoint), .ov_limit(ov_limit), .fault_status(fault_status), .alert_n(alert_n));
  pmb_host u_pmb_host (.clk(clk), .dev_addr(7'h5A), .req_ready(req_ready), .resp_valid(resp_valid),
    .resp(resp), .req_valid(req_valid), .req(req));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  ////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic run(input pmb_pkg::xfer_kind_e k, input logic [7:0] cd, input logic [15:0] d, input logic err);
    u_pmb_host.xfer(k, cd, d, 1'b1, 1'b0, r, got);
    check(got, 1'b1);
    check(r.err, err);
  endtask
  task automatic rd(input pmb_pkg::xfer_kind_e k, input logic [7:0] cd, input logic [15:0] exp);
    run(k, cd, 16'h0000, 1'b0);
    check(r.data, exp);
    check(r.pec, u_pmb_host.frame_pec(cd, 1'b1, exp, k == pmb_pkg::KIND_READ_WORD ? 2 : 1));
  endtask
  ////////////////////////////////////////
  task automatic t_defaults;
    logic [7:0] codes [6];
    logic [15:0] vals [6];
    pmb_pkg::xfer_kind_e k;
    codes = '{8'h01, 8'h02, 8'h20, 8'h21, 8'h33, 8'h40};
    vals = '{16'h0080, 16'h001D, 16'h0014, 16'hC000, 16'hF208, 16'hF000};
    for (int i = 0; i < 6; i++) begin
      if (i < 3) k = pmb_pkg::KIND_READ_BYTE;
      else k = pmb_pkg::KIND_READ_WORD;
      rd(k, codes[i], vals[i]);
    end
    check(conv_on, 1'b0);
    $display("defaults done");
  endtask
  task automatic t_setpoint;
    run(pmb_pkg::KIND_WRITE_WORD, 8'h21, 16'h999A, 1'b0);
    run(pmb_pkg::KIND_WRITE_WORD, 8'h21, 16'hA000, 1'b0);
    rd(pmb_pkg::KIND_READ_WORD, 8'h21, 16'hA000);
    run(pmb_pkg::KIND_WRITE_WORD, 8'h21, 16'hD334, 1'b1);
    check(vout_setpoint, 16'hA000);
    check({fault_status[2], alert_n}, 2'b10);
    u_pmb_host.xfer(pmb_pkg::KIND_WRITE_WORD, 8'h21, 16'hB000, 1'b1, 1'b1, r, got);
    check({got, r.err, fault_status[1]}, 3'b111);
    check(vout_setpoint, 16'hA000);
    run(pmb_pkg::KIND_WRITE_BYTE, 8'h20, 16'h0000, 1'b1);
    check(fault_status[0], 1'b1);
    $display("setpoint done");
  endtask
  task automatic t_clear;
    @(negedge clk);
    fault_evt = 4'h5;
    @(negedge clk);
    fault_evt = 4'h0;
    check(fault_status[7:4], 4'h5);
    run(pmb_pkg::KIND_SEND, 8'h03, 16'h0000, 1'b0);
    check({fault_status, alert_n}, 9'h001);
    $display("clear done");
  endtask
  task automatic t_freq_onoff;
    run(pmb_pkg::KIND_WRITE_WORD, 8'h33, 16'hE9E0, 1'b1);
    run(pmb_pkg::KIND_WRITE_WORD, 8'h33, 16'hF231, 1'b1);
    run(pmb_pkg::KIND_WRITE_WORD, 8'h33, 16'hF1E0, 1'b0);
    check(freq_setpoint, 16'hF1E0);
    @(negedge clk);
    on_off_pin = 1'b0;
    @(negedge clk);
    check(conv_on, 1'b1);
    // The pin now turns the output on, so the frequency write and the restore are refused
    run(pmb_pkg::KIND_WRITE_WORD, 8'h33, 16'hF208, 1'b1);
    run(pmb_pkg::KIND_SEND, 8'h12, 16'h0000, 1'b1);
    check(fault_status[3], 1'b1);
    check(freq_setpoint, 16'hF1E0);
    run(pmb_pkg::KIND_WRITE_BYTE, 8'h01, 16'h0000, 1'b0);
    check(conv_on, 1'b0);
    run(pmb_pkg::KIND_WRITE_BYTE, 8'h01, 16'h0080, 1'b0);
    @(negedge clk);
    on_off_pin = 1'b1;
    $display("frequency and on/off done");
  endtask
  task automatic t_store;
    run(pmb_pkg::KIND_WRITE_WORD, 8'h40, 16'hA000, 1'b1);
    run(pmb_pkg::KIND_WRITE_WORD, 8'h40, 16'hF800, 1'b0);
    check(ov_limit, 16'hF800);
    run(pmb_pkg::KIND_SEND, 8'h11, 16'h0000, 1'b0);
    run(pmb_pkg::KIND_WRITE_WORD, 8'h21, 16'hB000, 1'b0);
    run(pmb_pkg::KIND_SEND, 8'h12, 16'h0000, 1'b0);
    rd(pmb_pkg::KIND_READ_WORD, 8'h21, 16'hA000);
    rd(pmb_pkg::KIND_READ_WORD, 8'h33, 16'hF1E0);
    $display("store and restore done");
  endtask
  task automatic t_pos_strap;
    @(negedge clk);
    nrst = 1'b0;
    pol_strap = 1'b1;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    repeat (2) @(negedge clk);
    rd(pmb_pkg::KIND_READ_BYTE, 8'h02, 16'h001F);
    check(conv_on, 1'b1);
    $display("positive strap done");
  endtask
  ////////////////////////////////////////
  initial begin
    nrst = 1'b0;
    pol_strap = 1'b0;
    on_off_pin = 1'b1;
    fault_evt = 4'h0;
    repeat (16) @(negedge clk);
    nrst = 1'b1;
    repeat (2) @(negedge clk);
    t_defaults();
    t_setpoint();
    t_clear();
    t_freq_onoff();
    t_store();
    t_pos_strap();
    end_of_test();
  end
  // Tests need about a hundred cycles; 5000 leaves room for every bounded wait
  initial begin
    #20000;
    miscompares++;
    end_of_test();
  end
endmodule // power_cmd_test
